// ---- rtl/slpm_mode_ctrl.sv ----
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Host's first command services watchdog; here it only leaves Init, no watchdog timer exists
// [RULE2] No undervoltage or fail at power-up
// [RULE3] Reset output low below reset threshold
// [RULE4] Wake in Normal/Stop: interrupt, no change
// [RULE5] Second supply, high-side default off
// [RULE6] From Init: supply3, CAN, LIN off
// [RULE7] From Restart third supply kept
// [RULE8] Fail outputs off, kept after failure
// [RULE9] Fail-output test bit drives fail outputs
// [RULE10] Cyclic sense/wake timer selection
// [RULE11] Stop filters writes, sets serial failure
// [RULE12] Stop keeps Normal settings, supply on
// [RULE13] Stop entry interrupts on pending wake
// [RULE14] Stop to Sleep goes to Restart
// [RULE15] Measurement select removes wake one, two
// [RULE16] Sleep: supply off, wake via Restart
// [RULE17] Sleep entry makes transceivers wake capable
// [RULE18] Sleep: watchdog off, cyclic wake off
// [RULE19] Sleep entry recorded in status field
// [RULE20] Sleep without wake sources goes Restart
// [RULE21] Pending wake flags force immediate wake
// [RULE22] Faulted switch stops cyclic sense
// [RULE23] Mode bits cleared through Restart
// [RULE24] Any command in Init goes Normal
// [RULE25] Restart holds reset low for delay
// [RULE26] Requests checked, state updated once
module slpm_mode_ctrl
  import slpm_pkg::*;
#(
  parameter int RESET_DELAY = RESET_DELAY_CYC,
  parameter int NUM_HS = 4,
  parameter int NUM_WAKE = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_supply_below_reset_threshold,
  input wire logic battery_below_short_threshold,
  input wire logic failure_event,
  input wire logic can_wake,
  input wire logic lin_wake,
  input wire logic [NUM_WAKE-1:0] wake_inputs,
  input wire logic [NUM_HS-1:0] hs_fault,
  output logic main_supply_en,
  output logic second_supply_en,
  output logic third_supply_en,
  output logic [1:0] can_mode,
  output logic [1:0] lin_mode,
  output logic [NUM_HS-1:0] high_side_outputs,
  output logic [NUM_HS-1:0] cyclic_sense_en,
  output logic cyclic_sense_timer,
  output logic cyclic_wake_en,
  output logic cyclic_wake_timer,
  output logic watchdog_en,
  output logic fail_outputs,
  output logic reset_output_n,
  output logic int_n,
  output logic main_supply_undervoltage_flag,
  output logic [2:0] mode_state
);
  slpm_state_t state_q;
  logic [31:0] cfg_q;
  logic [1:0] mode_bits_q;
  logic [NUM_WAKE+1:0] wake_en_q;
  logic [NUM_WAKE+1:0] wake_stat_one_q;
  logic [NUM_HS-1:0] wake_stat_two_q;
  logic [1:0] devst_q;
  logic spi_fail_q;
  logic fail_latched_q;
  logic int_q;
  logic [31:0] rst_cnt_q;
  logic uv_q;
  logic wr_acc;
  logic rd_acc;
  logic stop_allowed;
  logic [NUM_WAKE+1:0] wake_hits;
  logic [NUM_WAKE+1:0] wake_eff_en;
  logic wake_any;
  logic wake_pending;
  logic [1:0] req_mode;
  logic mode_wr;
  logic power_up_quiet;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign req_mode = pwdata[1:0];
  assign mode_wr = wr_acc && paddr == MODE_CTRL_OFS;
  assign power_up_quiet = main_supply_below_reset_threshold
    && battery_below_short_threshold; // [RULE2]

  // Wake sources; measurement use blocks wake inputs one and two
  always_comb begin
    wake_eff_en = wake_en_q;
    if (cfg_q[CFG_MEAS_BIT]) begin
      wake_eff_en[1:0] = 2'b00; // [RULE15]
    end
  end
  assign wake_hits = {can_wake, lin_wake, wake_inputs} & wake_eff_en;
  assign wake_any = |wake_hits;
  assign wake_pending = (|wake_stat_one_q) || (|wake_stat_two_q);

  // Writes allowed in Stop: mode change to Normal, commands, status clear
  always_comb begin
    stop_allowed = 1'b0;
    if (paddr == MODE_CTRL_OFS && req_mode == MODE_REQ_NORMAL) begin
      stop_allowed = 1'b1;
    end else if (paddr == CMD_OFS) begin
      stop_allowed = 1'b1;
    end else if (paddr == WAKE_STAT_ONE_OFS) begin
      stop_allowed = 1'b1;
    end else if (paddr == WAKE_STAT_TWO_OFS) begin
      stop_allowed = 1'b1;
    end else if (paddr == DEV_STATUS_OFS) begin
      stop_allowed = 1'b1;
    end
  end

  // Mode state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SLPM_INIT;
      mode_bits_q <= MODE_REQ_NORMAL;
      rst_cnt_q <= '0;
    end else begin
      case (state_q)
        SLPM_INIT: begin
          if (psel && penable) begin
            state_q <= SLPM_NORMAL; // [RULE24]
          end else if (failure_event) begin
            state_q <= SLPM_RESTART;
          end
        end
        SLPM_NORMAL: begin
          if (failure_event) begin
            state_q <= SLPM_RESTART;
          end else if (mode_wr) begin // [RULE26]
            mode_bits_q <= req_mode;
            if (req_mode == MODE_REQ_STOP) begin
              state_q <= SLPM_STOP;
            end else if (req_mode == MODE_REQ_SLEEP) begin
              if (wake_eff_en == '0) begin
                state_q <= SLPM_RESTART; // [RULE20]
              end else if (wake_pending) begin
                state_q <= SLPM_RESTART; // [RULE21]
              end else begin
                state_q <= SLPM_SLEEP;
              end
            end
          end
        end
        SLPM_STOP: begin
          if (failure_event) begin
            state_q <= SLPM_RESTART;
          end else if (mode_wr && req_mode == MODE_REQ_SLEEP) begin
            state_q <= SLPM_RESTART; // [RULE14]
          end else if (mode_wr && req_mode == MODE_REQ_NORMAL) begin
            state_q <= SLPM_NORMAL;
            mode_bits_q <= MODE_REQ_NORMAL;
          end else if (wr_acc && paddr == CMD_OFS
                       && pwdata[CMD_SOFT_RST_BIT]) begin
            state_q <= SLPM_RESTART;
          end
        end
        SLPM_SLEEP: begin
          if (wake_any || wake_pending) begin
            state_q <= SLPM_RESTART; // [RULE16]
          end
        end
        default: begin
          mode_bits_q <= MODE_REQ_NORMAL; // [RULE23]
          if (main_supply_below_reset_threshold) begin
            rst_cnt_q <= '0;
          end else if (rst_cnt_q >= 32'(RESET_DELAY - 1)) begin
            rst_cnt_q <= '0;
            state_q <= SLPM_NORMAL; // [RULE25]
          end else begin
            rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
          end
        end
      endcase
      if (state_q == SLPM_NORMAL && wr_acc && paddr == CMD_OFS
          && pwdata[CMD_SOFT_RST_BIT]) begin
        state_q <= SLPM_RESTART;
      end
    end
  end

  // Configuration; frozen outside Normal, cleared parts on Restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0; // [RULE5] [RULE6]
      wake_en_q <= '1;
    end else if (state_q == SLPM_RESTART) begin
      cfg_q[CFG_SUPPLY2_BIT] <= 1'b0;
      cfg_q[CFG_HS_LSB +: NUM_HS] <= '0; // [RULE5]
      cfg_q[CFG_FOTEST_BIT] <= 1'b0;
      // Third supply bit untouched [RULE7]
      if (cfg_q[CFG_CAN_LSB +: 2] != XCVR_OFF) begin
        cfg_q[CFG_CAN_LSB +: 2] <= XCVR_WAKE; // [RULE6]
      end
      if (cfg_q[CFG_LIN_LSB +: 2] != XCVR_OFF) begin
        cfg_q[CFG_LIN_LSB +: 2] <= XCVR_WAKE;
      end
    end else if (mode_wr && req_mode == MODE_REQ_SLEEP
                 && state_q == SLPM_NORMAL) begin
      if (cfg_q[CFG_CAN_LSB +: 2] != XCVR_OFF) begin
        cfg_q[CFG_CAN_LSB +: 2] <= XCVR_WAKE; // [RULE17]
      end
      if (cfg_q[CFG_LIN_LSB +: 2] != XCVR_OFF) begin
        cfg_q[CFG_LIN_LSB +: 2] <= XCVR_WAKE;
      end
    end else if (state_q == SLPM_NORMAL && wr_acc) begin
      if (paddr == CFG_CTRL_OFS) begin
        cfg_q <= pwdata; // [RULE9] [RULE10]
      end else if (paddr == WAKE_CTRL_OFS) begin
        wake_en_q <= pwdata[NUM_WAKE+1:0];
      end
    end
  end

  // Wake flags: set wins over clear, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_stat_one_q <= '0;
      wake_stat_two_q <= '0;
    end else begin
      if (state_q != SLPM_INIT) begin
        wake_stat_one_q <= (wake_stat_one_q
          & ~((wr_acc && paddr == WAKE_STAT_ONE_OFS)
              ? pwdata[NUM_WAKE+1:0] : '0)) | wake_hits;
      end
      wake_stat_two_q <= (wake_stat_two_q
        & ~((wr_acc && paddr == WAKE_STAT_TWO_OFS)
            ? pwdata[NUM_HS-1:0] : '0)) | hs_fault;
    end
  end

  // Serial failure and device status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_fail_q <= 1'b0;
      devst_q <= DEVST_NONE;
    end else begin
      if (state_q == SLPM_STOP && wr_acc && !stop_allowed) begin
        spi_fail_q <= 1'b1; // [RULE11]
      end else if (state_q == SLPM_STOP && mode_wr
                   && req_mode == MODE_REQ_SLEEP) begin
        spi_fail_q <= 1'b1; // [RULE14]
      end else if (state_q == SLPM_NORMAL && mode_wr
                   && req_mode == MODE_REQ_SLEEP
                   && wake_eff_en == '0) begin
        spi_fail_q <= 1'b1; // [RULE20]
      end else if (wr_acc && paddr == DEV_STATUS_OFS && pwdata[2]) begin
        spi_fail_q <= 1'b0;
      end
      if (state_q == SLPM_SLEEP) begin
        devst_q <= DEVST_SLEEP; // [RULE19]
      end else if (state_q == SLPM_RESTART && devst_q != DEVST_SLEEP) begin
        devst_q <= DEVST_RESTART;
      end else if (wr_acc && paddr == DEV_STATUS_OFS
                   && pwdata[1:0] != DEVST_NONE) begin
        devst_q <= DEVST_NONE;
      end
    end
  end

  // Fail latch, undervoltage flag, interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_latched_q <= 1'b0; // [RULE8]
      uv_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      if (failure_event && !power_up_quiet) begin
        fail_latched_q <= 1'b1; // [RULE8]
      end
      if (main_supply_below_reset_threshold && !power_up_quiet) begin
        uv_q <= 1'b1; // [RULE2]
      end else if (wr_acc && paddr == DEV_STATUS_OFS && pwdata[3]) begin
        uv_q <= 1'b0;
      end
      if ((state_q == SLPM_NORMAL || state_q == SLPM_STOP) && wake_any) begin
        int_q <= 1'b1; // [RULE4]
      end else if (state_q == SLPM_NORMAL && mode_wr
                   && req_mode == MODE_REQ_STOP && wake_pending) begin
        int_q <= 1'b1; // [RULE13]
      end else if (rd_acc && paddr == WAKE_STAT_ONE_OFS) begin
        int_q <= 1'b0;
      end
    end
  end

  // Register read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == MODE_CTRL_OFS) begin
        prdata <= {29'h0, state_q == SLPM_STOP, mode_bits_q};
      end else if (paddr == CFG_CTRL_OFS) begin
        prdata <= cfg_q;
      end else if (paddr == WAKE_CTRL_OFS) begin
        prdata <= 32'(wake_en_q);
      end else if (paddr == WAKE_STAT_ONE_OFS) begin
        prdata <= 32'(wake_stat_one_q);
      end else if (paddr == WAKE_STAT_TWO_OFS) begin
        prdata <= 32'(wake_stat_two_q);
      end else if (paddr == DEV_STATUS_OFS) begin
        prdata <= {28'h0, uv_q, spi_fail_q, devst_q};
      end else begin
        prdata <= '0;
      end
    end
  end

  // Outputs per mode; Stop keeps Normal settings, Sleep turns off supply, watchdog, cyclic wake [RULE12] [RULE18]
  assign main_supply_en = state_q != SLPM_SLEEP; // [RULE16]
  assign second_supply_en = cfg_q[CFG_SUPPLY2_BIT];
  assign third_supply_en = cfg_q[CFG_SUPPLY3_BIT];
  assign can_mode = cfg_q[CFG_CAN_LSB +: 2];
  assign lin_mode = cfg_q[CFG_LIN_LSB +: 2];
  assign high_side_outputs = cfg_q[CFG_HS_LSB +: NUM_HS];
  genvar g;
  generate
    for (g = 0; g < NUM_HS; g++) begin : g_cs
      // Faulted switch cannot sense
      assign cyclic_sense_en[g] = cfg_q[CFG_CSENSE_LSB + g]
        && !hs_fault[g]; // [RULE22]
    end
  endgenerate
  assign cyclic_sense_timer = cfg_q[CFG_CSENSE_TMR_BIT]; // [RULE10]
  assign cyclic_wake_en = cfg_q[CFG_CWAKE_EN_BIT]
    && state_q != SLPM_SLEEP; // [RULE18]
  assign cyclic_wake_timer = cfg_q[CFG_CWAKE_TMR_BIT];
  assign watchdog_en = state_q != SLPM_SLEEP;
  assign fail_outputs = fail_latched_q
    || (cfg_q[CFG_FOTEST_BIT] && state_q != SLPM_INIT); // [RULE9]
  assign reset_output_n = !main_supply_below_reset_threshold
    && state_q != SLPM_RESTART; // [RULE3] [RULE25]
  assign int_n = !int_q;
  assign main_supply_undervoltage_flag = uv_q;
  assign mode_state = state_q;

  property p_stop_sleep_restart;
    @(posedge pclk) disable iff (!presetn)
    (state_q == SLPM_STOP && mode_wr && req_mode == MODE_REQ_SLEEP)
      |=> state_q == SLPM_RESTART && spi_fail_q;
  endproperty
  a_stop_sleep_restart: assert property (p_stop_sleep_restart) // [RULE14]
    else $error("stop to sleep not refused");

  property p_reset_low;
    @(posedge pclk) disable iff (!presetn)
    main_supply_below_reset_threshold |-> !reset_output_n;
  endproperty
  a_reset_low: assert property (p_reset_low) // [RULE3]
    else $error("reset output high under threshold");

  property p_wake_int;
    @(posedge pclk) disable iff (!presetn)
    (state_q == SLPM_NORMAL && wake_any && !failure_event && !wr_acc)
      |=> !int_n && state_q == SLPM_NORMAL;
  endproperty
  a_wake_int: assert property (p_wake_int) // [RULE4]
    else $error("wake in normal mishandled");

  property p_init_any_cmd;
    @(posedge pclk) disable iff (!presetn)
    (state_q == SLPM_INIT && psel && penable) |=> state_q == SLPM_NORMAL;
  endproperty
  a_init_any_cmd: assert property (p_init_any_cmd) // [RULE24]
    else $error("init did not leave on command");

  property p_sleep_supply;
    @(posedge pclk) disable iff (!presetn)
    state_q == SLPM_SLEEP |-> !main_supply_en && !watchdog_en;
  endproperty
  a_sleep_supply: assert property (p_sleep_supply) // [RULE16]
    else $error("supply or watchdog on in sleep");

  property p_sleep_status;
    @(posedge pclk) disable iff (!presetn)
    state_q == SLPM_SLEEP |=> devst_q == DEVST_SLEEP;
  endproperty
  a_sleep_status: assert property (p_sleep_status) // [RULE19]
    else $error("sleep not recorded");

  property p_restart_clears;
    @(posedge pclk) disable iff (!presetn)
    state_q == SLPM_RESTART |=> mode_bits_q == MODE_REQ_NORMAL;
  endproperty
  a_restart_clears: assert property (p_restart_clears) // [RULE23]
    else $error("mode bits not cleared");

  property p_stop_filter;
    @(posedge pclk) disable iff (!presetn)
    (state_q == SLPM_STOP && wr_acc && !stop_allowed)
      |=> spi_fail_q && $stable(cfg_q);
  endproperty
  a_stop_filter: assert property (p_stop_filter) // [RULE11]
    else $error("stop write not filtered");
endmodule : slpm_mode_ctrl

// ---- rtl/slpm_pkg.sv ----
package slpm_pkg;
  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_CTRL_OFS = 8'h04;
  localparam logic [7:0] WAKE_CTRL_OFS = 8'h08;
  localparam logic [7:0] WAKE_STAT_ONE_OFS = 8'h0C;
  localparam logic [7:0] WAKE_STAT_TWO_OFS = 8'h10;
  localparam logic [7:0] DEV_STATUS_OFS = 8'h14;
  localparam logic [7:0] CMD_OFS = 8'h18;

  // Mode field encoding in the mode control register
  localparam logic [1:0] MODE_REQ_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REQ_SLEEP = 2'h1;
  localparam logic [1:0] MODE_REQ_STOP = 2'h2;

  // Device status field codes
  localparam logic [1:0] DEVST_NONE = 2'h0;
  localparam logic [1:0] DEVST_RESTART = 2'h1;
  localparam logic [1:0] DEVST_SLEEP = 2'h2;

  // Config register fields
  localparam int CFG_SUPPLY2_BIT = 0;
  localparam int CFG_SUPPLY3_BIT = 1;
  localparam int CFG_FOTEST_BIT = 2;
  localparam int CFG_MEAS_BIT = 3;
  localparam int CFG_CSENSE_TMR_BIT = 4;
  localparam int CFG_CWAKE_EN_BIT = 5;
  localparam int CFG_CWAKE_TMR_BIT = 6;
  localparam int CFG_CAN_LSB = 8;
  localparam int CFG_LIN_LSB = 10;
  localparam int CFG_HS_LSB = 12;
  localparam int CFG_CSENSE_LSB = 16;

  // Command register bits
  localparam int CMD_SOFT_RST_BIT = 0;
  localparam int CMD_WD_REFRESH_BIT = 1;

  // Transceiver modes
  localparam logic [1:0] XCVR_OFF = 2'h0;
  localparam logic [1:0] XCVR_WAKE = 2'h1;
  localparam logic [1:0] XCVR_RXONLY = 2'h2;
  localparam logic [1:0] XCVR_ON = 2'h3;

  // Reset delay time in microseconds and cycles at 200 MHz
  localparam int RESET_DELAY_US = 10;
  localparam int CLK_MHZ = 200;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * CLK_MHZ;

  typedef enum logic [2:0] {
    SLPM_INIT = 3'b000,
    SLPM_NORMAL = 3'b001,
    SLPM_STOP = 3'b010,
    SLPM_SLEEP = 3'b011,
    SLPM_RESTART = 3'b100
  } slpm_state_t;
endpackage : slpm_pkg

// ---- verif/slpm_host_model.sv ----
`timescale 1ns/1ps
module slpm_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Request held until pready is seen high at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask : rd
endmodule : slpm_host_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top
  import slpm_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic below_thr, bat_low, fail_ev;
  logic [4:0] wk;
  logic [3:0] hs_fault, hs, sense;
  logic ms_en, s2_en, s3_en, cs_tmr, cw_en, cw_tmr, wd_en, fo, rst_n;
  logic int_n, uv;
  logic [1:0] can_mode, lin_mode;
  logic [2:0] mode_state;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  slpm_mode_ctrl #(.RESET_DELAY(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .main_supply_below_reset_threshold(below_thr),
    .battery_below_short_threshold(bat_low), .failure_event(fail_ev),
    .can_wake(wk[4]), .lin_wake(wk[3]), .wake_inputs(wk[2:0]),
    .hs_fault(hs_fault), .main_supply_en(ms_en), .second_supply_en(s2_en),
    .third_supply_en(s3_en), .can_mode(can_mode), .lin_mode(lin_mode),
    .high_side_outputs(hs), .cyclic_sense_en(sense),
    .cyclic_sense_timer(cs_tmr), .cyclic_wake_en(cw_en),
    .cyclic_wake_timer(cw_tmr), .watchdog_en(wd_en), .fail_outputs(fo),
    .reset_output_n(rst_n), .int_n(int_n),
    .main_supply_undervoltage_flag(uv), .mode_state(mode_state));

  slpm_host_model host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  task results;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  task stl;
    repeat (2) @(posedge pclk);
    #1;
  endtask : stl

  task pulse(input int i);
    @(posedge pclk);
    wk[i] <= 1'b1;
    repeat (2) @(posedge pclk);
    wk[i] <= 1'b0;
    stl();
  endtask : pulse

  // Restart lasts the shortened reset delay; bound the wait generously
  task wmode(input logic [2:0] s);
    int n;
    n = 0;
    while (mode_state !== s && n < 200) begin
      @(posedge pclk);
      n++;
    end
    #1;
  endtask : wmode

  initial begin
    presetn = 1'b0;
    below_thr = 1'b1;
    bat_low = 1'b1;
    fail_ev = 1'b0;
    wk = 5'h00;
    hs_fault = 4'h0;
    repeat (12) @(posedge pclk);
    #1;
    `CHK(rst_n, 1'b0)
    presetn <= 1'b1;
    stl();
    `CHK(uv, 1'b0)
    `CHK(fo, 1'b0)
    `CHK(rst_n, 1'b0)
    `CHK(mode_state, SLPM_INIT)
    below_thr <= 1'b0;
    bat_low <= 1'b0;
    host.wr(CMD_OFS, 32'h0000_0002);
    stl();
    `CHK(mode_state, SLPM_NORMAL)
    `CHK({s2_en, s3_en, hs}, 6'h00)
    `CHK({can_mode, lin_mode}, 4'h0)
    `CHK(fo, 1'b0)
    host.wr(CFG_CTRL_OFS, 32'h000F_FB77);
    stl();
    `CHK({s2_en, s3_en, fo}, 3'h7)
    `CHK({can_mode, lin_mode, hs}, 8'hEF)
    `CHK({sense, cs_tmr, cw_en, cw_tmr}, 7'h7F)
    hs_fault <= 4'h1;
    stl();
    `CHK(sense, 4'hE)
    hs_fault <= 4'h0;
    host.rd(WAKE_STAT_TWO_OFS, d);
    `CHK(d[3:0], 4'h1)
    // Stale switch flag would block every later Sleep entry
    host.wr(WAKE_STAT_TWO_OFS, 32'h0000_000F);
    host.wr(CFG_CTRL_OFS, 32'h000F_FB73);
    stl();
    `CHK(fo, 1'b0)
    pulse(0);
    `CHK(int_n, 1'b0)
    `CHK(mode_state, SLPM_NORMAL)
    host.rd(WAKE_STAT_ONE_OFS, d);
    `CHK(d[0], 1'b1)
    host.wr(MODE_CTRL_OFS, {30'h0, MODE_REQ_STOP});
    stl();
    `CHK(mode_state, SLPM_STOP)
    `CHK(int_n, 1'b0)
    host.rd(WAKE_STAT_ONE_OFS, d);
    host.wr(WAKE_STAT_ONE_OFS, 32'h0000_001F);
    pulse(4);
    `CHK(int_n, 1'b0)
    `CHK(mode_state, SLPM_STOP)
    host.rd(WAKE_STAT_ONE_OFS, d);
    host.wr(WAKE_STAT_ONE_OFS, 32'h0000_001F);
    host.wr(CFG_CTRL_OFS, 32'h0000_0000);
    stl();
    `CHK({ms_en, s2_en, s3_en, hs}, 7'h7F)
    `CHK({can_mode, lin_mode, sense}, 8'hEF)
    host.rd(DEV_STATUS_OFS, d);
    `CHK(d[2], 1'b1)
    host.wr(MODE_CTRL_OFS, {30'h0, MODE_REQ_SLEEP});
    stl();
    `CHK(mode_state, SLPM_RESTART)
    `CHK(rst_n, 1'b0)
    wmode(SLPM_NORMAL);
    `CHK(mode_state, SLPM_NORMAL)
    `CHK(rst_n, 1'b1)
    `CHK({s2_en, hs}, 5'h00)
    `CHK(s3_en, 1'b1)
    `CHK(can_mode, XCVR_WAKE)
    host.rd(MODE_CTRL_OFS, d);
    `CHK(d[1:0], 2'h0)
    host.rd(DEV_STATUS_OFS, d);
    `CHK(d[2:0], {1'b1, DEVST_RESTART})
    host.wr(DEV_STATUS_OFS, 32'h0000_000F);
    host.wr(WAKE_CTRL_OFS, 32'h0000_0000);
    host.wr(MODE_CTRL_OFS, {30'h0, MODE_REQ_SLEEP});
    stl();
    `CHK(mode_state, SLPM_RESTART)
    wmode(SLPM_NORMAL);
    host.rd(DEV_STATUS_OFS, d);
    `CHK(d[2], 1'b1)
    host.wr(DEV_STATUS_OFS, 32'h0000_000F);
    host.wr(WAKE_CTRL_OFS, 32'h0000_001F);
    pulse(3);
    host.wr(MODE_CTRL_OFS, {30'h0, MODE_REQ_SLEEP});
    stl();
    `CHK(mode_state, SLPM_RESTART)
    wmode(SLPM_NORMAL);
    host.wr(WAKE_STAT_ONE_OFS, 32'h0000_001F);
    host.wr(CFG_CTRL_OFS, 32'h0000_0008);
    pulse(0);
    host.rd(WAKE_STAT_ONE_OFS, d);
    `CHK(d[0], 1'b0)
    host.wr(WAKE_STAT_ONE_OFS, 32'h0000_001F);
    // CAN parked wake capable beforehand, LIN left on to see auto change
    host.wr(CFG_CTRL_OFS, 32'h000F_FD73);
    host.wr(MODE_CTRL_OFS, {30'h0, MODE_REQ_SLEEP});
    stl();
    `CHK(mode_state, SLPM_SLEEP)
    `CHK({ms_en, wd_en, cw_en}, 3'h0)
    `CHK({can_mode, lin_mode}, {XCVR_WAKE, XCVR_WAKE})
    `CHK({s2_en, hs, sense}, 9'h1FF)
    pulse(4);
    wmode(SLPM_NORMAL);
    `CHK(mode_state, SLPM_NORMAL)
    host.rd(WAKE_STAT_ONE_OFS, d);
    `CHK(d[4], 1'b1)
    host.rd(DEV_STATUS_OFS, d);
    `CHK(d[1:0], DEVST_SLEEP)
    @(posedge pclk);
    fail_ev <= 1'b1;
    @(posedge pclk);
    fail_ev <= 1'b0;
    stl();
    `CHK(mode_state, SLPM_RESTART)
    wmode(SLPM_NORMAL);
    `CHK(fo, 1'b1)
    results();
  end
endmodule : tb_top
